// ==== rtl/mcw_pkg.sv ====
package mcw_pkg;
  // System clock
  localparam int unsigned CLK_HZ            = 100_000_000;
  // Default watchdog interval, in microseconds; unused, the interval comes from i_wd_timeout_us
  localparam int unsigned WD_TIMEOUT_US_RST = 3000;
  localparam int unsigned WD_TICK_NS        = 1000;
  localparam int unsigned WD_TICK_CYCLES    = (WD_TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
  // Common blink half-period
  localparam int unsigned BLINK_HALF_MS     = 250;
  localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * (CLK_HZ / 1000);
  // Node poll supervision
  localparam int unsigned NODE_MISS_LIMIT   = 4;
  localparam int unsigned WD_WIDTH          = 24;
  localparam int unsigned NODE_COUNT        = 16;
  typedef enum logic [1:0] {
    MCW_RS_IDLE,
    MCW_RS_INIT,
    MCW_RS_UP,
    MCW_RS_DROP
  } mcw_rs_state_t;
endpackage : mcw_pkg

// ==== rtl/mcw_watchdog_status.sv ====
// Functional notes
// - Host sample call restarts watchdog count
// - Host programs interval; missed call expires
// - Expired flag visible to host
// - Expiry forces power enables low in hardware
// - Supervision only while enable setting true
// - Power enable needs request, no expiry, no fault
// - CAN LED blink traffic, on full, off idle
// - RS485 LED blink init, on up, off drop
// - Drop node that stops answering polls
// - Host-running LED blinks while software runs
// - Boot LED steady after successful boot
// - Error LED off clean, blink on PCI error
// - Error LED steady on watchdog overflow
`timescale 1ns/10ps
module mcw_watchdog_status
  import mcw_pkg::*;
#(
  parameter int unsigned AXES        = 6,
  parameter int unsigned NODES       = NODE_COUNT,
  parameter int unsigned BLINK_HALF  = BLINK_HALF_CYCLES,
  parameter int unsigned MISS_LIMIT  = NODE_MISS_LIMIT
) (
  input  wire logic                i_mclk,            // System clock
  input  wire logic                i_resetn,          // Sync reset, active low
  input  wire logic                i_host_sample_call,// Sampling function pulse
  input  wire logic                i_wd_enable,       // Watchdog enable setting
  input  wire logic [WD_WIDTH-1:0] i_wd_timeout_us,   // Watchdog interval, us
  input  wire logic                i_power_enable,    // Host power-enable request
  input  wire logic [AXES-1:0]     i_power_fault_pin, // Amplifier fault pins
  input  wire logic                i_can_activity,    // CAN data exchange pulse
  input  wire logic                i_can_buf_full,    // Any CAN buffer full
  input  wire logic                i_rs_init_busy,    // Node initialization running
  input  wire logic [NODES-1:0]    i_node_present,    // Nodes found at init
  input  wire logic                i_poll_round,      // End of a poll round pulse
  input  wire logic [NODES-1:0]    i_node_answered,   // Nodes answering this round
  input  wire logic                i_host_running,    // Host control software alive
  input  wire logic                i_boot_ok,         // Card booted successfully
  input  wire logic                i_pci_error,       // PCI communication error
  output logic                     o_wd_expired,      // Watchdog expired flag
  output logic [AXES:0]            o_power_enable,    // Axis and CAN enables
  output logic [NODES-1:0]         o_node_active,     // Nodes in active service
  output logic                     o_can_led,         // CAN indicator
  output logic                     o_rs485_led,       // RS485 indicator
  output logic                     o_host_running_led,// Host running indicator
  output logic                     o_boot_led,        // Boot indicator
  output logic                     o_error_led        // Error indicator
);

  // Refuse sizes that the counters below cannot serve
  if (AXES < 1) begin : g_chk_axes
    $error("mcw_watchdog_status: AXES must be at least 1");
  end
  if (NODES < 1) begin : g_chk_nodes
    $error("mcw_watchdog_status: NODES must be at least 1");
  end
  if (BLINK_HALF < 2) begin : g_chk_blink
    $error("mcw_watchdog_status: BLINK_HALF must be at least 2");
  end
  if (MISS_LIMIT < 1 || MISS_LIMIT > 255) begin : g_chk_miss
    $error("mcw_watchdog_status: MISS_LIMIT must lie in 1 to 255");
  end
  if (WD_TICK_CYCLES < 1) begin : g_chk_tick
    $error("mcw_watchdog_status: microsecond tick needs a clock of at least 1 MHz");
  end

  localparam int unsigned BW = $clog2(BLINK_HALF);
  localparam int unsigned TW = $clog2(WD_TICK_CYCLES + 1);

  // Fault pins come from outside the clock domain
  logic [AXES-1:0] flt_s1_reg, flt_s1_next;
  logic [AXES-1:0] flt_s2_reg, flt_s2_next;
  logic            fault_seen;
  always_comb begin
    flt_s1_next = i_power_fault_pin;
    flt_s2_next = flt_s1_reg;
    // Any synced fault drops every enable; faults are not kept per axis
    fault_seen  = (flt_s2_reg != '0);
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      flt_s1_reg <= '0;
      flt_s2_reg <= '0;
    end else begin
      flt_s1_reg <= flt_s1_next;
      flt_s2_reg <= flt_s2_next;
    end
  end

  // Common blink generator
  logic [BW-1:0] blink_cnt_reg, blink_cnt_next;
  logic          blink_reg, blink_next;
  logic          blink_step;
  always_comb begin
    blink_step     = (blink_cnt_reg == BW'(BLINK_HALF - 1));
    blink_cnt_next = blink_cnt_reg + 1'b1;
    blink_next     = blink_reg;
    if (blink_step) begin
      blink_cnt_next = '0;
      blink_next     = ~blink_reg;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b0;
    end else begin
      blink_cnt_reg <= blink_cnt_next;
      blink_reg     <= blink_next;
    end
  end

  // Watchdog: microsecond tick plus interval counter
  logic [TW-1:0]       tick_cnt_reg, tick_cnt_next;
  logic [WD_WIDTH-1:0] wd_cnt_reg, wd_cnt_next;
  logic                expired_reg, expired_next;
  logic                tick;
  always_comb begin
    tick          = (tick_cnt_reg == TW'(WD_TICK_CYCLES - 1));
    tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
    wd_cnt_next   = wd_cnt_reg;
    expired_next  = expired_reg;
    if (!i_wd_enable) begin
      wd_cnt_next   = '0;
      tick_cnt_next = '0;
      expired_next  = 1'b0;
    end else if (i_host_sample_call) begin
      wd_cnt_next   = '0;
      tick_cnt_next = '0;
    end else if (tick && !expired_reg) begin
      wd_cnt_next = wd_cnt_reg + 1'b1;
      // A zero interval expires on the first tick
      if (wd_cnt_next >= i_wd_timeout_us) begin
        expired_next = 1'b1;
      end
    end
  end
  // Expiry is sticky while enabled; a late sample call does not re-arm power
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      tick_cnt_reg <= '0;
      wd_cnt_reg   <= '0;
      expired_reg  <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      wd_cnt_reg   <= wd_cnt_next;
      expired_reg  <= expired_next;
    end
  end

  // Node supervision: miss counters per node
  // Any answer clears the count, so only consecutive misses drop a node
  logic [NODES-1:0] active_reg, active_next;
  logic [7:0]       miss_reg [NODES];
  logic [7:0]       miss_next [NODES];
  genvar g;
  generate
    for (g = 0; g < NODES; g++) begin : g_node
      always_comb begin
        miss_next[g]   = miss_reg[g];
        active_next[g] = active_reg[g];
        if (i_rs_init_busy) begin
          miss_next[g]   = '0;
          active_next[g] = i_node_present[g];
        end else if (i_poll_round && active_reg[g]) begin
          if (i_node_answered[g]) begin
            miss_next[g] = '0;
          end else if (miss_reg[g] == 8'(MISS_LIMIT - 1)) begin
            active_next[g] = 1'b0;
          end else begin
            miss_next[g] = miss_reg[g] + 8'h01;
          end
        end
      end
      always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
          miss_reg[g]   <= 8'h00;
          active_reg[g] <= 1'b0;
        end else begin
          miss_reg[g]   <= miss_next[g];
          active_reg[g] <= active_next[g];
        end
      end
    end
  endgenerate

  // RS485 bus state
  // Drop holds until a fresh init so a lost node stays visible
  mcw_rs_state_t rs_reg, rs_next;
  always_comb begin
    rs_next = rs_reg;
    unique case (rs_reg)
      MCW_RS_IDLE: if (i_rs_init_busy) rs_next = MCW_RS_INIT;
      MCW_RS_INIT: if (!i_rs_init_busy) rs_next = MCW_RS_UP;
      MCW_RS_UP: begin
        if (i_rs_init_busy) rs_next = MCW_RS_INIT;
        else if ((active_reg & i_node_present) != i_node_present) rs_next = MCW_RS_DROP;
      end
      MCW_RS_DROP: if (i_rs_init_busy) rs_next = MCW_RS_INIT;
    endcase
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) rs_reg <= MCW_RS_IDLE;
    else rs_reg <= rs_next;
  end

  // CAN activity stretched over BLINK_HALF - 1 cycles, one less than a blink half-period, so short bursts show
  logic [BW-1:0] can_hold_reg, can_hold_next;
  always_comb begin
    can_hold_next = can_hold_reg;
    if (i_can_activity) can_hold_next = BW'(BLINK_HALF - 1);
    else if (can_hold_reg != '0) can_hold_next = can_hold_reg - 1'b1;
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) can_hold_reg <= '0;
    else can_hold_reg <= can_hold_next;
  end

  // Lamp modes shared by every indicator
  typedef enum logic [1:0] {
    MCW_LAMP_OFF,
    MCW_LAMP_ON,
    MCW_LAMP_BLINK
  } mcw_lamp_t;

  // All blinking lamps follow one phase, so they flash in step
  function automatic logic lamp_drive(input mcw_lamp_t mode, input logic phase);
    logic lit;
    lit = 1'b0;
    unique case (mode)
      MCW_LAMP_OFF:   lit = 1'b0;
      MCW_LAMP_ON:    lit = 1'b1;
      MCW_LAMP_BLINK: lit = phase;
      default:        lit = 1'b0;
    endcase
    return lit;
  endfunction : lamp_drive

  // Power outputs: expiry cuts the enables on the edge that raises the flag
  logic [AXES:0] pwr_next;
  always_comb begin
    pwr_next = '0;
    if (i_power_enable && !expired_next && !fault_seen) begin
      pwr_next = '1;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_wd_expired   <= 1'b0;
      o_power_enable <= '0;
    end else begin
      o_wd_expired   <= expired_next;
      o_power_enable <= pwr_next;
    end
  end

  // Indicator and node outputs
  mcw_lamp_t   can_mode, rs_mode, run_mode, boot_mode, err_mode;
  logic        can_led_next, rs_led_next, run_led_next, boot_led_next, err_led_next;
  always_comb begin
    // Full buffer outranks ordinary traffic
    if (i_can_buf_full) can_mode = MCW_LAMP_ON;
    else if (can_hold_reg != '0) can_mode = MCW_LAMP_BLINK;
    else can_mode = MCW_LAMP_OFF;
    unique case (rs_reg)
      MCW_RS_INIT:              rs_mode = MCW_LAMP_BLINK;
      MCW_RS_UP:                rs_mode = MCW_LAMP_ON;
      MCW_RS_IDLE, MCW_RS_DROP: rs_mode = MCW_LAMP_OFF;
    endcase
    run_mode  = i_host_running ? MCW_LAMP_BLINK : MCW_LAMP_OFF;
    boot_mode = i_boot_ok ? MCW_LAMP_ON : MCW_LAMP_OFF;
    // Same-edge expiry so the lamp never lags the flag
    if (expired_next) err_mode = MCW_LAMP_ON;
    else if (i_pci_error) err_mode = MCW_LAMP_BLINK;
    else err_mode = MCW_LAMP_OFF;
    can_led_next  = lamp_drive(can_mode, blink_reg);
    rs_led_next   = lamp_drive(rs_mode, blink_reg);
    run_led_next  = lamp_drive(run_mode, blink_reg);
    boot_led_next = lamp_drive(boot_mode, blink_reg);
    err_led_next  = lamp_drive(err_mode, blink_reg);
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_node_active      <= '0;
      o_can_led          <= 1'b0;
      o_rs485_led        <= 1'b0;
      o_host_running_led <= 1'b0;
      o_boot_led         <= 1'b0;
      o_error_led        <= 1'b0;
    end else begin
      o_node_active      <= active_next;
      o_can_led          <= can_led_next;
      o_rs485_led        <= rs_led_next;
      o_host_running_led <= run_led_next;
      o_boot_led         <= boot_led_next;
      o_error_led        <= err_led_next;
    end
  end

endmodule : mcw_watchdog_status

// ==== bench/mcw_watchdog_status_props.sv ====
`timescale 1ns/10ps
module mcw_watchdog_status_chk
  import mcw_pkg::*;
#(parameter int unsigned AXES = 6) (
  input wire logic            i_mclk,             // Clock
  input wire logic            i_resetn,           // Reset
  input wire logic            i_wd_enable,        // Supervision on
  input wire logic [AXES-1:0] i_power_fault_pin,  // Faults
  input wire logic            i_power_enable,     // Request
  input wire logic            i_can_buf_full,     // Buffer full
  input wire logic            i_boot_ok,          // Booted
  input wire logic            o_wd_expired,       // Expired
  input wire logic [AXES:0]   o_power_enable,     // Enables
  input wire logic            o_can_led,          // CAN lamp
  input wire logic            o_boot_led,         // Boot lamp
  input wire logic            o_error_led         // Error lamp
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  AST_PWR_CUT: assert property (o_wd_expired |-> o_power_enable == '0)
    else $error("enable high while expired");
  AST_PWR_SAME: assert property (o_power_enable == '0 || &o_power_enable)
    else $error("enables differ");
  AST_PWR_REQ: assert property (!i_power_enable |=> o_power_enable == '0)
    else $error("enable without request");
  AST_PWR_FLT: assert property ((|i_power_fault_pin)[*4] |-> o_power_enable == '0)
    else $error("enable during fault");
  AST_EXP_OFF: assert property (!i_wd_enable |=> !o_wd_expired)
    else $error("expiry while disabled");
  AST_EXP_HOLD: assert property (o_wd_expired && i_wd_enable |=> o_wd_expired)
    else $error("expiry flag lost");
  AST_ERR_ON: assert property (o_wd_expired |-> o_error_led)
    else $error("error lamp dark on expiry");
  AST_BOOT: assert property (1 |=> o_boot_led == $past(i_boot_ok))
    else $error("boot lamp wrong");
  AST_CAN_FULL: assert property (i_can_buf_full[*2] |-> o_can_led)
    else $error("CAN lamp dark when full");
endmodule : mcw_watchdog_status_chk
bind mcw_watchdog_status mcw_watchdog_status_chk #(.AXES(AXES)) chk_u (.*);

// ==== bench/tb.sv ====
`timescale 1ns/10ps
module tb;
  import mcw_pkg::*;
  logic clk, rstn, call, wde, pwr, can_act, can_full, rs_busy, poll, host, boot, pci, expired;
  logic [WD_WIDTH-1:0] tmo;
  logic [5:0] flt;
  logic [6:0] pen;
  logic [15:0] present, answered, active;
  logic [4:0] leds;
  int failures, comparisons;
  mcw_watchdog_status #(.BLINK_HALF(4), .MISS_LIMIT(2)) dut_u (
    .i_mclk(clk), .i_resetn(rstn), .i_host_sample_call(call), .i_wd_enable(wde), .i_wd_timeout_us(tmo),
    .i_power_enable(pwr), .i_power_fault_pin(flt), .i_can_activity(can_act), .i_can_buf_full(can_full),
    .i_rs_init_busy(rs_busy), .i_node_present(present), .i_poll_round(poll), .i_node_answered(answered),
    .i_host_running(host), .i_boot_ok(boot), .i_pci_error(pci), .o_wd_expired(expired),
    .o_power_enable(pen), .o_node_active(active), .o_can_led(leds[4]), .o_rs485_led(leds[3]),
    .o_host_running_led(leds[2]), .o_boot_led(leds[1]), .o_error_led(leds[0]));
  task automatic check(string name, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic look(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : look
  // Counts lamp changes over 20 cycles; blink half period is 4
  task automatic blinks(string name, int idx, logic want);
    int flips;
    logic prev;
    flips = 0;
    prev = leds[idx];
    repeat (20) begin
      look(1);
      if (leds[idx] !== prev) flips++;
      prev = leds[idx];
    end
    check(name, 16'(want), 16'(flips >= 2));
  endtask : blinks
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    failures++;
    wrap_up();
  end
  initial begin
    {call, wde, pwr, can_act, can_full, rs_busy, poll, host, boot, pci} = '0;
    {tmo, flt, present, answered, rstn} = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    look(2);
    check("enables", 16'h0000, 16'(pen));
    @(posedge clk) pwr <= 1'b1;
    look(3);
    check("enables", 16'h007F, 16'(pen));
    @(posedge clk) flt <= 6'h08;
    look(5);
    check("enables", 16'h0000, 16'(pen));
    @(posedge clk) flt <= 6'h00;
    look(5);
    check("enables", 16'h007F, 16'(pen));
    $display("power test done");
    @(posedge clk) {wde, call, tmo} <= {2'b11, 24'h000003};
    repeat (3) begin
      @(posedge clk) call <= 1'b0;
      look(98);
      check("expired", 16'h0000, 16'(expired));
      @(posedge clk) call <= 1'b1;
    end
    @(posedge clk) call <= 1'b0;
    look(295);
    check("expired", 16'h0000, 16'(expired));
    look(10);
    check("expired", 16'h0001, 16'(expired));
    check("enables", 16'h0000, 16'(pen));
    check("error lamp", 16'h0001, 16'(leds[0]));
    @(posedge clk) {call, pci} <= 2'b11;
    @(posedge clk) call <= 1'b0;
    look(12);
    check("expired", 16'h0001, 16'(expired));
    blinks("error lamp steady", 0, 1'b0);
    @(posedge clk) {wde, pci} <= 2'b00;
    look(3);
    check("expired", 16'h0000, 16'(expired));
    check("enables", 16'h007F, 16'(pen));
    look(400);
    check("expired", 16'h0000, 16'(expired));
    $display("watchdog test done");
    @(posedge clk) pci <= 1'b1;
    blinks("error lamp", 0, 1'b1);
    @(posedge clk) {pci, host, boot} <= 3'b011;
    blinks("host lamp", 2, 1'b1);
    check("error lamp", 16'h0000, 16'(leds[0]));
    check("boot lamp", 16'h0001, 16'(leds[1]));
    @(posedge clk) {host, can_full} <= 2'b01;
    look(3);
    check("host lamp", 16'h0000, 16'(leds[2]));
    check("can lamp", 16'h0001, 16'(leds[4]));
    // Activity held high: back to back exchanges
    @(posedge clk) {can_full, can_act} <= 2'b01;
    blinks("can lamp", 4, 1'b1);
    @(posedge clk) {can_act, rs_busy, present} <= {2'b01, 16'h0003};
    look(12);
    check("can lamp", 16'h0000, 16'(leds[4]));
    blinks("rs lamp", 3, 1'b1);
    check("active", 16'h0003, active);
    @(posedge clk) rs_busy <= 1'b0;
    look(3);
    check("rs lamp", 16'h0001, 16'(leds[3]));
    repeat (2) begin
      check("active", 16'h0003, active);
      @(posedge clk) {poll, answered} <= {1'b1, 16'h0001};
      @(posedge clk) poll <= 1'b0;
      look(2);
    end
    check("active", 16'h0001, active);
    check("rs lamp", 16'h0000, 16'(leds[3]));
    $display("lamp test done");
    wrap_up();
  end
endmodule : tb
